/* File: design/gen_timer_pkg.sv */
// Constants and carrier types for the general timer block
package gen_timer_pkg;

  // Configuration select codes
  localparam logic [2:0] CFG_TIMER32 = 3'h0;
  localparam logic [2:0] CFG_RTC32 = 3'h1;
  localparam logic [2:0] CFG_SPLIT16 = 3'h4;

  // Low half mode field codes
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;

  // Reset and preload values
  localparam logic [15:0] HALF_RESET = 16'hffff;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [31:0] MATCH_RESET = 32'hffff_ffff;
  localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
  localparam logic [31:0] RTC_ROLL = 32'h0000_0000;

  // Clock-mode divider: pin rate down to one tick per second
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam int RTC_DIV_DEFAULT = RTC_IN_HZ / RTC_OUT_HZ;

  // Control strobes and levels
  typedef struct packed {
    logic en_set;
    logic en_clr;
    logic adc_trig_en;
    logic lo_stall;
    logic hi_stall;
    logic clock_mode_enable;
  } ctl_t;

  // Status, mask and clear bits
  typedef struct packed {
    logic clock_match;
    logic lo_timeout;
  } irq_bits_t;

endpackage

/* File: design/general_timer_block.sv */
// Two 16-bit counters joined as a 32-bit timer or 32-bit clock counter
`timescale 1ns/1ns
// How it works
// - Reset sets both counters and load registers to 0xffff, control cleared.
// - Reset sets both prescale registers to 0x00.
// - Config 0 gives 32-bit timer, config 1 gives 32-bit clock counter.
// - In 32-bit modes a load write fills high half from upper 16 bits.
// - Count output shows high half above low half.
// - Only the low half mode field picks one-shot or periodic.
// - Enabled counter counts down and reloads after reaching zero.
// - One-shot clears its enable at time-out; periodic keeps counting.
// - Time-out sets raw status, held until cleared.
// - Unmasked time-out also sets masked status.
// - Time-out pulses the ADC trigger only when trigger enable is set.
// - ADC triggers of all blocks are ORed outside; enable one only.
// - Load write while running loads the counter next cycle.
// - With stall set the counter holds while the debugger halts.
// - Clock mode counts up, loaded with one when first selected.
// - Pin clock divided to one tick per second increments the counter.
// - Count equal to match rolls over to zero and keeps counting.
// - Match sets raw and, if unmasked, masked match status.
// - In clock mode, clock-mode enable makes both stall bits ignored.
// - In 32-bit configs halves act only as one 32-bit timer or one 32-bit clock counter.
// - Config 0x4 selects split 16-bit use; the joined counter idles.
module general_timer_block #(
  parameter int RTC_DIV = gen_timer_pkg::RTC_DIV_DEFAULT
) (
  input wire logic i_core_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic [2:0] i_cfg, // Configuration select level
  input wire logic [1:0] i_lo_mode, // Low half mode field
  input wire gen_timer_pkg::ctl_t i_ctl, // Control strobes and levels
  input wire logic i_load_wr, // Interval load write strobe
  input wire logic [31:0] i_load_data, // Interval load write data
  input wire logic i_match_wr, // Match write strobe
  input wire logic [31:0] i_match_data, // Match write data
  input wire logic i_prescale_wr, // Prescale write strobe
  input wire logic [15:0] i_prescale_data, // Prescale data, high byte to high half
  input wire gen_timer_pkg::irq_bits_t i_irq_mask, // Interrupt mask levels
  input wire gen_timer_pkg::irq_bits_t i_irq_clear, // Write-one-to-clear strobes
  input wire logic i_debug_halt, // Processor halted by debugger
  input wire logic i_capture_compare_pin0, // Capture pin, clock input
  output logic [31:0] o_count, // Joined count value
  output logic [15:0] o_lo_load, // Low half interval load
  output logic [15:0] o_hi_load, // High half interval load
  output logic [7:0] o_lo_prescale, // Low half prescale
  output logic [7:0] o_hi_prescale, // High half prescale
  output logic o_lo_enable, // Low half enable bit
  output gen_timer_pkg::irq_bits_t o_raw_status, // Raw status
  output gen_timer_pkg::irq_bits_t o_masked_status, // Masked status
  output logic o_adc_trigger // ADC trigger pulse
);

  localparam logic [15:0] DIV_LAST = 16'(RTC_DIV - 1);

  logic [31:0] cnt_reg, cnt_next;
  logic [15:0] lo_load_reg, lo_load_next;
  logic [15:0] hi_load_reg, hi_load_next;
  logic [31:0] match_reg, match_next;
  logic [7:0] lo_pre_reg, lo_pre_next;
  logic [7:0] hi_pre_reg, hi_pre_next;
  logic en_reg, en_next;
  logic rtc_seen_reg, rtc_seen_next;
  logic [15:0] div_reg, div_next;
  gen_timer_pkg::irq_bits_t raw_reg, raw_next;
  gen_timer_pkg::irq_bits_t mis_reg, mis_next;
  logic adc_reg, adc_next;
  logic ccp_s1_reg, ccp_s2_reg, ccp_s3_reg;
  logic freeze, timeout_evt, match_evt, tick, mode_timer, mode_rtc;

  // Pin synchroniser and edge history
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ccp_s1_reg <= 1'b0;
      ccp_s2_reg <= 1'b0;
      ccp_s3_reg <= 1'b0;
    end
    else
    begin
      ccp_s1_reg <= i_capture_compare_pin0;
      ccp_s2_reg <= ccp_s1_reg;
      ccp_s3_reg <= ccp_s2_reg;
    end
  end

  always_comb
  begin
    mode_timer = (i_cfg == gen_timer_pkg::CFG_TIMER32);
    mode_rtc = (i_cfg == gen_timer_pkg::CFG_RTC32);
    // debug stall, ignored in clock mode when clock-mode enable is set
    if (mode_rtc)
      freeze = i_debug_halt && (i_ctl.lo_stall || i_ctl.hi_stall) && !i_ctl.clock_mode_enable;
    else
      freeze = i_debug_halt && i_ctl.lo_stall;
    cnt_next = cnt_reg;
    lo_load_next = lo_load_reg;
    hi_load_next = hi_load_reg;
    match_next = match_reg;
    lo_pre_next = lo_pre_reg;
    hi_pre_next = hi_pre_reg;
    en_next = en_reg;
    rtc_seen_next = rtc_seen_reg;
    div_next = div_reg;
    timeout_evt = 1'b0;
    match_evt = 1'b0;
    tick = 1'b0;
    if (i_prescale_wr)
    begin
      lo_pre_next = i_prescale_data[7:0];
      hi_pre_next = i_prescale_data[15:8];
    end
    if (i_match_wr)
      match_next = i_match_data;
    if (i_load_wr)
    begin
      lo_load_next = i_load_data[15:0];
      if (mode_timer || mode_rtc)
        hi_load_next = i_load_data[31:16];
    end
    if (i_ctl.en_clr)
      en_next = 1'b0;
    if (mode_timer)
    begin
      // running reload from a load write
      if (i_load_wr)
        cnt_next = i_load_data;
      else if (en_reg && !freeze)
      begin
        if (cnt_reg == 32'h0000_0000)
        begin
          cnt_next = {hi_load_reg, lo_load_reg};
          timeout_evt = 1'b1;
          if (i_lo_mode == gen_timer_pkg::MODE_ONESHOT)
            en_next = 1'b0;
        end
        else
          cnt_next = cnt_reg - 32'h0000_0001;
      end
    end
    else if (mode_rtc)
    begin
      if (!rtc_seen_reg)
      begin
        cnt_next = gen_timer_pkg::RTC_FIRST;
        rtc_seen_next = 1'b1;
      end
      else if (en_reg && !freeze)
      begin
        // divide pin clock to one tick
        if (ccp_s2_reg && !ccp_s3_reg)
        begin
          if (div_reg == DIV_LAST)
          begin
            div_next = 16'h0000;
            tick = 1'b1;
          end
          else
            div_next = div_reg + 16'h0001;
        end
        if (cnt_reg == match_reg)
        begin
          cnt_next = gen_timer_pkg::RTC_ROLL;
          match_evt = 1'b1;
        end
        else if (tick)
          cnt_next = cnt_reg + 32'h0000_0001;
      end
    end
    // Set wins over a same-cycle hardware clear
    if (i_ctl.en_set)
      en_next = 1'b1;
  end

  always_comb
  begin
    // one clears, set wins over clear
    raw_next = raw_reg & ~i_irq_clear;
    if (timeout_evt)
      raw_next.lo_timeout = 1'b1;
    if (match_evt)
      raw_next.clock_match = 1'b1;
    mis_next = raw_next & i_irq_mask;
    adc_next = timeout_evt && i_ctl.adc_trig_en;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_reg <= {gen_timer_pkg::HALF_RESET, gen_timer_pkg::HALF_RESET};
      lo_load_reg <= gen_timer_pkg::HALF_RESET;
      hi_load_reg <= gen_timer_pkg::HALF_RESET;
      match_reg <= gen_timer_pkg::MATCH_RESET;
      lo_pre_reg <= gen_timer_pkg::PRESCALE_RESET;
      hi_pre_reg <= gen_timer_pkg::PRESCALE_RESET;
      en_reg <= 1'b0;
      rtc_seen_reg <= 1'b0;
      div_reg <= 16'h0000;
      raw_reg <= '0;
      mis_reg <= '0;
      adc_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      lo_load_reg <= lo_load_next;
      hi_load_reg <= hi_load_next;
      match_reg <= match_next;
      lo_pre_reg <= lo_pre_next;
      hi_pre_reg <= hi_pre_next;
      en_reg <= en_next;
      rtc_seen_reg <= rtc_seen_next;
      div_reg <= div_next;
      raw_reg <= raw_next;
      mis_reg <= mis_next;
      adc_reg <= adc_next;
    end
  end

  assign o_count = cnt_reg;
  assign o_lo_load = lo_load_reg;
  assign o_hi_load = hi_load_reg;
  assign o_lo_prescale = lo_pre_reg;
  assign o_hi_prescale = hi_pre_reg;
  assign o_lo_enable = en_reg;
  assign o_raw_status = raw_reg;
  assign o_masked_status = mis_reg;
  // single-cycle pulse for an external OR
  assign o_adc_trigger = adc_reg;

  logic after_rst_reg;
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      after_rst_reg <= 1'b0;
    else
      after_rst_reg <= 1'b1;
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_RESET_STATE: assert property (
    !after_rst_reg |-> o_count == 32'hffff_ffff && o_lo_load == 16'hffff
      && o_hi_load == 16'hffff && !o_lo_enable && o_raw_status == '0)
    else $error("Reset state wrong");

  AST_PRESCALE_RESET: assert property (
    !after_rst_reg |-> o_lo_prescale == 8'h00 && o_hi_prescale == 8'h00)
    else $error("Prescale not zero after reset");

  AST_LOAD_JOIN: assert property (
    (mode_timer || mode_rtc) && i_load_wr |=> {o_hi_load, o_lo_load} == $past(i_load_data))
    else $error("Joined load write wrong");

  AST_LOAD_TAKE: assert property (
    i_load_wr && mode_timer |=> o_count == $past(i_load_data))
    else $error("Running load not taken");

  AST_COUNT_DOWN: assert property (
    mode_timer && o_lo_enable && !freeze && !i_load_wr && o_count != 32'h0
      |=> o_count == $past(o_count) - 32'h1)
    else $error("Counter did not decrement");

  AST_RELOAD: assert property (
    mode_timer && o_lo_enable && !freeze && !i_load_wr && o_count == 32'h0
      |=> o_count == $past({o_hi_load, o_lo_load}))
    else $error("Reload after zero wrong");

  AST_ONESHOT_STOP: assert property (
    timeout_evt && i_lo_mode == gen_timer_pkg::MODE_ONESHOT && !i_ctl.en_set |=> !o_lo_enable)
    else $error("One-shot did not stop");

  AST_TIMEOUT_RAW: assert property (
    timeout_evt |=> o_raw_status.lo_timeout ##1 (o_raw_status.lo_timeout
      || $past(i_irq_clear.lo_timeout)))
    else $error("Time-out status lost");

  AST_MASKED: assert property (
    timeout_evt && i_irq_mask.lo_timeout |=> o_masked_status.lo_timeout)
    else $error("Masked time-out not set");

  AST_ADC_GATE: assert property (
    o_adc_trigger |-> $past(timeout_evt) && $past(i_ctl.adc_trig_en))
    else $error("ADC trigger without enable");

  AST_STALL_HOLD: assert property (
    mode_timer && i_debug_halt && i_ctl.lo_stall && !i_load_wr |=> $stable(o_count))
    else $error("Counter moved while stalled");

  AST_RTC_FIRST: assert property (
    mode_rtc && !rtc_seen_reg |=> o_count == 32'h0000_0001)
    else $error("Clock mode first value wrong");

  AST_RTC_ROLL: assert property (
    match_evt |=> o_count == 32'h0 && o_raw_status.clock_match)
    else $error("Clock match roll-over wrong");

  AST_RTC_NO_STALL: assert property (
    mode_rtc && rtc_seen_reg && o_lo_enable && i_ctl.clock_mode_enable && ccp_s2_reg
      && !ccp_s3_reg && div_reg != DIV_LAST |=> div_reg == $past(div_reg) + 16'h0001)
    else $error("Clock mode froze despite enable");

  AST_SPLIT_IDLE: assert property (
    i_cfg == gen_timer_pkg::CFG_SPLIT16 |=> $stable(o_count))
    else $error("Joined counter moved in split config");

  AST_CLEAR: assert property (
    i_irq_clear.clock_match && !match_evt |=> !o_raw_status.clock_match
      && !o_masked_status.clock_match)
    else $error("Clear did not clear status");

  COV_PERIODIC: cover property (
    timeout_evt && i_lo_mode == gen_timer_pkg::MODE_PERIODIC ##1 o_lo_enable);
  COV_ONESHOT: cover property (
    timeout_evt && i_lo_mode == gen_timer_pkg::MODE_ONESHOT);
  COV_RTC_MATCH: cover property (match_evt);
  COV_ADC: cover property (o_adc_trigger);
endmodule

/* File: bench/general_timer_block_test.sv */
// Self-checking bench for the general timer block
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module general_timer_block_test;
  localparam int DIV = 4;
  typedef struct {int sel; logic [31:0] exp;} note_t;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [2:0] i_cfg = 3'h0;
  logic [1:0] i_lo_mode = 2'h0;
  gen_timer_pkg::ctl_t i_ctl = '0;
  logic i_load_wr = 1'b0;
  logic [31:0] i_load_data = 32'h0;
  logic i_match_wr = 1'b0;
  logic [31:0] i_match_data = 32'h0;
  logic i_prescale_wr = 1'b0;
  logic [15:0] i_prescale_data = 16'h0;
  gen_timer_pkg::irq_bits_t i_irq_mask = '0;
  gen_timer_pkg::irq_bits_t i_irq_clear = '0;
  logic i_debug_halt = 1'b0;
  logic i_capture_compare_pin0 = 1'b0;
  logic [31:0] o_count;
  logic [15:0] o_lo_load;
  logic [15:0] o_hi_load;
  logic [7:0] o_lo_prescale;
  logic [7:0] o_hi_prescale;
  logic o_lo_enable;
  gen_timer_pkg::irq_bits_t o_raw_status;
  gen_timer_pkg::irq_bits_t o_masked_status;
  logic o_adc_trigger;
  note_t q[$];
  int fail_count = 0;
  int comparisons = 0;
  string nm[8] = '{"count", "lo_load", "hi_load", "prescale", "enable", "raw", "masked", "adc"};

  general_timer_block #(.RTC_DIV(DIV)) uut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cfg(i_cfg), .i_lo_mode(i_lo_mode),
    .i_ctl(i_ctl), .i_load_wr(i_load_wr), .i_load_data(i_load_data),
    .i_match_wr(i_match_wr), .i_match_data(i_match_data), .i_prescale_wr(i_prescale_wr),
    .i_prescale_data(i_prescale_data), .i_irq_mask(i_irq_mask), .i_irq_clear(i_irq_clear),
    .i_debug_halt(i_debug_halt), .i_capture_compare_pin0(i_capture_compare_pin0), .o_count(o_count), .o_lo_load(o_lo_load),
    .o_hi_load(o_hi_load), .o_lo_prescale(o_lo_prescale), .o_hi_prescale(o_hi_prescale),
    .o_lo_enable(o_lo_enable), .o_raw_status(o_raw_status),
    .o_masked_status(o_masked_status), .o_adc_trigger(o_adc_trigger)
  );

  initial
  begin
    forever #10 i_core_clk = ~i_core_clk;
  end

  function automatic logic [31:0] seen(int s);
    case (s)
      0: return o_count;
      1: return {16'h0000, o_lo_load};
      2: return {16'h0000, o_hi_load};
      3: return {16'h0000, o_hi_prescale, o_lo_prescale};
      4: return {31'h0, o_lo_enable};
      5: return {30'h0, o_raw_status};
      6: return {30'h0, o_masked_status};
      default: return {31'h0, o_adc_trigger};
    endcase
  endfunction

  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A note holds for the outputs settled after the next rising edge
  task automatic note(int s, logic [31:0] e);
    q.push_back('{s, e});
  endtask

  task automatic step();
    @(negedge i_core_clk);
  endtask

  task automatic pin_edges(int n);
    repeat (n)
    begin
      i_capture_compare_pin0 = 1'b1;
      repeat (2) step();
      i_capture_compare_pin0 = 1'b0;
      repeat (2) step();
    end
  endtask

  task automatic run_timer(logic [1:0] mode, logic mask, logic trig, logic [31:0] d);
    step();
    i_lo_mode = mode;
    i_irq_mask.lo_timeout = mask;
    i_ctl.adc_trig_en = trig;
    i_load_wr = 1'b1;
    i_load_data = d;
    note(0, d);
    step();
    i_load_wr = 1'b0;
    i_ctl.en_set = 1'b1;
    note(4, 32'h1);
    step();
    i_ctl.en_set = 1'b0;
    for (int i = 1; i <= d; i++)
    begin
      note(0, d - i);
      step();
    end
    note(0, d);
    note(5, 32'h1);
    note(6, {31'h0, mask});
    note(7, {31'h0, trig});
    note(4, {31'h0, mode == gen_timer_pkg::MODE_PERIODIC});
    step();
    note(7, 32'h0);
    step();
    i_irq_clear = 2'b10;
    note(5, 32'h1);
    step();
    i_irq_clear = 2'b01;
    note(5, 32'h0);
    note(6, 32'h0);
    step();
    i_irq_clear = 2'b00;
  endtask

  initial
  begin : mon
    note_t n;
    forever
    begin
      @(posedge i_core_clk);
      #2;
      while (q.size() > 0)
      begin
        n = q.pop_front();
        `CHECK(nm[n.sel], n.exp, seen(n.sel))
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    complete_run();
  end

  initial
  begin : drive
    logic [31:0] d;
    logic [15:0] p;
    void'($urandom(37));
    d = $urandom();
    p = 16'($urandom());
    repeat (2) step();
    note(0, 32'hffff_ffff);
    note(1, 32'h0000_ffff);
    note(2, 32'h0000_ffff);
    note(4, 32'h0);
    note(5, 32'h0);
    note(7, 32'h0);
    note(6, 32'h0);
    note(3, 32'h0);
    step();
    i_resetn = 1'b1;
    i_cfg = gen_timer_pkg::CFG_TIMER32;
    i_load_wr = 1'b1;
    i_load_data = d;
    i_prescale_wr = 1'b1;
    i_prescale_data = p;
    note(0, d);
    note(1, {16'h0, d[15:0]});
    note(2, {16'h0, d[31:16]});
    note(3, {16'h0, p});
    step();
    i_load_wr = 1'b0;
    i_prescale_wr = 1'b0;
    d = 32'h4 + ($urandom() % 4);
    run_timer(gen_timer_pkg::MODE_ONESHOT, 1'b1, 1'b1, d);
    run_timer(gen_timer_pkg::MODE_PERIODIC, 1'b0, 1'b0, d);
    i_load_wr = 1'b1;
    i_load_data = 32'h0000_0100;
    note(0, 32'h0000_0100);
    step();
    i_load_wr = 1'b0;
    note(0, 32'h0000_00ff);
    step();
    i_ctl.lo_stall = 1'b1;
    i_debug_halt = 1'b1;
    note(0, 32'h0000_00ff);
    step();
    note(0, 32'h0000_00ff);
    step();
    i_debug_halt = 1'b0;
    note(0, 32'h0000_00fe);
    step();
    i_ctl.en_clr = 1'b1;
    note(4, 32'h0);
    step();
    i_ctl.en_clr = 1'b0;
    i_cfg = gen_timer_pkg::CFG_RTC32;
    i_irq_mask = 2'b11;
    step();
    note(0, gen_timer_pkg::RTC_FIRST);
    step();
    i_match_wr = 1'b1;
    i_match_data = 32'h3;
    step();
    i_match_wr = 1'b0;
    i_ctl.en_set = 1'b1;
    i_ctl.clock_mode_enable = 1'b1;
    i_ctl.hi_stall = 1'b1;
    i_debug_halt = 1'b1;
    step();
    i_ctl.en_set = 1'b0;
    pin_edges(DIV);
    repeat (6) step();
    note(0, 32'h2);
    step();
    pin_edges(DIV);
    repeat (6) step();
    note(0, gen_timer_pkg::RTC_ROLL);
    note(5, 32'h2);
    note(6, 32'h2);
    step();
    i_irq_clear = 2'b10;
    note(5, 32'h0);
    note(6, 32'h0);
    step();
    i_irq_clear = 2'b00;
    i_ctl = '0;
    i_ctl.en_clr = 1'b1;
    i_debug_halt = 1'b0;
    note(4, 32'h0);
    step();
    i_ctl.en_clr = 1'b0;
    i_cfg = gen_timer_pkg::CFG_SPLIT16;
    step();
    d = $urandom();
    i_load_wr = 1'b1;
    i_load_data = d;
    note(1, {16'h0, d[15:0]});
    note(2, 32'h0);
    note(0, 32'h0);
    step();
    i_load_wr = 1'b0;
    for (int k = 0; k < 5 && q.size() > 0; k++) step();
    if (q.size() > 0)
      fail_count++;
    complete_run();
  end
endmodule
